//--- rtl/dpi_pkg.sv
// Functional notes
// - Controller holds reset low at least 200 us.
// - Clock enable low 10 ns before reset release.
// - Wait 500 us after reset before clock enable.
// - Clock stable max(10 ns, 5 periods) beforehand.
// - NOP registered before clock enable rises.
// - Clock enable stays high until init completes.
// - Termination off in reset until enable registered.
// - Termination control held static low during init.
// - Reset exit wait before first mode write.
// - Mode writes ordered two, three, one, zero.
// - Bank selects pick target mode word.
// - Long calibration, then wait lock and calibration.
// - Mode word zero field layout.
// - Mode word zero loads on all-low command.
// - Reserved bank bit and A13 driven zero.
// - Recovery cycles at least write recovery time.
// - Loop reset bit clears itself after action.
// - Powerdown loop mode selects slow or fast exit.
package dpi_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  function automatic int cdiv(input int n, input int d);
    return (n + d - 1) / d;
  endfunction : cdiv

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : imax

  localparam int CLK_PERIOD_NS   = 40;
  localparam int CK_DIV          = 2;   // System clocks per link clock
  localparam int CK_PERIOD_NS    = CLK_PERIOD_NS * CK_DIV;
  localparam int T_RESET_HOLD_US = 200;
  localparam int T_CKE_SETUP_NS  = 10;
  localparam int T_INIT_US       = 500;
  localparam int T_STABLE_NS     = 10;
  localparam int STABLE_PERIODS  = 5;
  localparam int T_SELF_EXIT_NS  = 170;
  localparam int T_WR_NS         = 15;
  localparam int RESET_HOLD_CK_DEF =
    cdiv(T_RESET_HOLD_US * 1000, CK_PERIOD_NS);
  localparam int CKE_SETUP_CK    =
    imax(cdiv(T_CKE_SETUP_NS, CK_PERIOD_NS), 1);
  localparam int STABLE_CK       =
    imax(cdiv(T_STABLE_NS, CK_PERIOD_NS), STABLE_PERIODS);
  localparam int INIT_WAIT_CK_DEF =
    imax(cdiv(T_INIT_US * 1000, CK_PERIOD_NS), STABLE_CK);
  localparam int EXIT_WAIT_CK    =
    imax(cdiv(T_SELF_EXIT_NS, CK_PERIOD_NS), STABLE_PERIODS);
  localparam int MODE_GAP_CK     = 4;
  localparam int LOCK_CK         = 512;
  localparam int CAL_INIT_CK     = 512;
  localparam int READY_WAIT_CK   = imax(LOCK_CK, CAL_INIT_CK);
  localparam int WR_MIN_CK       = cdiv(T_WR_NS, CK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Link pins and commands ({chip sel, row, column, write}, low active)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int BA_W   = 3;
  localparam logic [3:0] CMD_MODE = 4'h0;
  localparam logic [3:0] CMD_CAL  = 4'h6;
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [1:0] SEL_ZERO  = 2'h0;
  localparam logic [1:0] SEL_ONE   = 2'h1;
  localparam logic [1:0] SEL_TWO   = 2'h2;
  localparam logic [1:0] SEL_THREE = 2'h3;
  localparam logic [1:0] MODE_ORDER [4] =
    '{SEL_TWO, SEL_THREE, SEL_ONE, SEL_ZERO};

  // ----------------------------------------------------------------
  // Operating mode word fields
  // ----------------------------------------------------------------
  localparam int BURST_SIZE_LSB  = 0;
  localparam int LAT_LOW_BIT     = 2;
  localparam int BURST_ORDER_BIT = 3;
  localparam int LAT_LSB         = 4;
  localparam int TEST_BIT        = 7;
  localparam int LOOP_RESET_BIT  = 8;
  localparam int RECOV_LSB       = 9;
  localparam int CAL_LONG_BIT    = 10;
  localparam int PD_LOOP_BIT     = 12;
  localparam int RSVD_BIT        = 13;
  localparam int LOOP_ENABLE_BIT = 0;
  localparam logic [ADDR_W-1:0] MODE_WORD_RESET = 14'h0000;
  localparam logic [1:0] BURST_RSVD = 2'h3;

  // Latency code {A6,A5,A4,A2}; zero marks a reserved code
  function automatic logic [3:0] read_latency_ck(input logic [3:0] c);
    unique case (c)
      4'h4:    return 4'h6;
      4'h6:    return 4'h7;
      4'h8:    return 4'h8;
      4'hA:    return 4'h9;
      4'hC:    return 4'hA;
      default: return 4'h0;
    endcase
  endfunction : read_latency_ck

  // Recovery code; zero marks a reserved code
  function automatic logic [3:0] recovery_ck(input logic [2:0] c);
    unique case (c)
      3'h1:    return 4'h5;
      3'h2:    return 4'h6;
      3'h3:    return 4'h7;
      3'h4:    return 4'h8;
      3'h5:    return 4'hA;
      3'h6:    return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : recovery_ck

endpackage : dpi_pkg

//--- rtl/dpi_link_if.sv
`timescale 1ns/10ps
// Command and control pins between controller and memory
interface dpi_link_if;
  import dpi_pkg::*;
  logic              ck;
  logic              reset_n;
  logic              cke;
  logic [3:0]        cmd_n;
  logic [BA_W-1:0]   ba;
  logic [ADDR_W-1:0] addr;
  logic              termination_control;

  modport ctrl (output ck, reset_n, cke, cmd_n, ba, addr,
                termination_control);
  modport dev  (input  ck, reset_n, cke, cmd_n, ba, addr,
                termination_control);
endinterface : dpi_link_if

//--- rtl/dpi_mem_dev.sv
`timescale 1ns/10ps
module dpi_mem_dev
  import dpi_pkg::*;
(
  dpi_link_if.dev          link,
  output logic             termination_on_o,
  output logic [1:0]       burst_size_o,
  output logic             burst_order_o,
  output logic [3:0]       read_latency_o,
  output logic             test_select_o,
  output logic [3:0]       recovery_o,
  output logic             powerdown_loop_o,
  output logic             loop_reset_o,
  output logic             cal_long_o,
  output logic             mode_reserved_o
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic                cke_prev;
  logic                cke_seen;
  logic [ADDR_W-1:0]   mode_word;
  wire logic           take;
  wire logic           zero_wr;
  wire logic           cal_wr;
  wire logic [3:0]     lat_code;

  // Commands count only while clock enable is high on both edges
  assign take     = cke_prev & link.cke;
  assign zero_wr  = take & (link.cmd_n == CMD_MODE)
                  & (link.ba == {1'b0, SEL_ZERO});
  assign cal_wr   = take & (link.cmd_n == CMD_CAL)
                  & link.addr[CAL_LONG_BIT];
  assign lat_code = {mode_word[LAT_LSB+2:LAT_LSB],
                     mode_word[LAT_LOW_BIT]};

  // Link state; reset pin clears it regardless of the clock
  always_ff @(posedge link.ck or negedge link.reset_n) begin
    if (!link.reset_n) begin
      cke_prev  <= 1'b0;
      cke_seen  <= 1'b0;
      mode_word <= MODE_WORD_RESET;
    end else begin
      cke_prev <= link.cke;
      cke_seen <= cke_seen | link.cke;
      if (zero_wr) begin
        mode_word <= link.addr;
      end else begin
        // Loop reset is acted on once, then reads back as zero
        mode_word[LOOP_RESET_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  // Fields decode one link cycle after the write lands
  always_ff @(posedge link.ck or negedge link.reset_n) begin
    if (!link.reset_n) begin
      termination_on_o <= 1'b0;
      burst_size_o     <= 2'h0;
      burst_order_o    <= 1'b0;
      read_latency_o   <= 4'h0;
      test_select_o    <= 1'b0;
      recovery_o       <= 4'h0;
      powerdown_loop_o <= 1'b0;
      loop_reset_o     <= 1'b0;
      cal_long_o       <= 1'b0;
      mode_reserved_o  <= 1'b0;
    end else begin
      termination_on_o <= cke_seen & link.termination_control;
      burst_size_o     <= mode_word[BURST_SIZE_LSB+1:BURST_SIZE_LSB];
      burst_order_o    <= mode_word[BURST_ORDER_BIT];
      read_latency_o   <= read_latency_ck(lat_code);
      test_select_o    <= mode_word[TEST_BIT];
      recovery_o       <= recovery_ck(mode_word[RECOV_LSB+2:RECOV_LSB]);
      // High keeps the loop running in powerdown: fast exit
      powerdown_loop_o <= mode_word[PD_LOOP_BIT];
      loop_reset_o     <= mode_word[LOOP_RESET_BIT];
      cal_long_o       <= cal_wr;
      // Code 3 of burst size and zero decodes are reserved
      mode_reserved_o  <=
        (mode_word[BURST_SIZE_LSB+1:BURST_SIZE_LSB] == BURST_RSVD)
        | (read_latency_ck(lat_code) == 4'h0)
        | (recovery_ck(mode_word[RECOV_LSB+2:RECOV_LSB]) == 4'h0)
        | mode_word[TEST_BIT];
    end
  end

endmodule : dpi_mem_dev

//--- rtl/dpi_mem_ctrl.sv
`timescale 1ns/10ps
module dpi_mem_ctrl
  import dpi_pkg::*;
#(
  parameter int RESET_HOLD_CK = RESET_HOLD_CK_DEF,
  parameter int INIT_WAIT_CK  = INIT_WAIT_CK_DEF
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] mode_two_i,
  input  wire logic [ADDR_W-1:0] mode_three_i,
  input  wire logic [ADDR_W-1:0] mode_one_i,
  input  wire logic [ADDR_W-1:0] mode_zero_i,
  output logic                   ready_o,
  dpi_link_if.ctrl               link
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_HOLD,
    ST_INIT,
    ST_EXIT,
    ST_MODE,
    ST_CAL,
    ST_LOCK,
    ST_READY
  } dpi_state_t;

  dpi_state_t        state;
  dpi_state_t        next_state;
  logic [15:0]       cnt;
  logic [15:0]       next_cnt;
  logic [1:0]        idx;
  logic [1:0]        next_idx;
  logic              ck_q;
  wire logic         step;
  wire logic         done;
  wire logic         mode_issue;
  wire logic         cal_issue;
  wire logic [1:0]   slot_sel;
  wire logic [ADDR_W-1:0] slot_word;

  // ----------------------------------------------------------------
  // Mode word preparation
  // ----------------------------------------------------------------
  // Pick the smallest recovery code that meets the write recovery
  // time when the requested code falls short or is reserved
  function automatic logic [2:0] fix_recovery(input logic [2:0] c);
    logic [2:0] best;
    best = c;
    if (int'(recovery_ck(c)) < WR_MIN_CK ||
        recovery_ck(c) == 4'h0) begin
      for (int k = 6; k >= 1; k--) begin
        if (int'(recovery_ck(3'(k))) >= WR_MIN_CK) begin
          best = 3'(k);
        end
      end
    end
    return best;
  endfunction : fix_recovery

  // Word zero always requests a loop reset, reserved bit cleared
  function automatic logic [ADDR_W-1:0] prep_zero(
    input logic [ADDR_W-1:0] w
  );
    logic [ADDR_W-1:0] r;
    r = w;
    r[RSVD_BIT]       = 1'b0;
    r[LOOP_RESET_BIT] = 1'b1;
    r[RECOV_LSB+2:RECOV_LSB] =
      fix_recovery(w[RECOV_LSB+2:RECOV_LSB]);
    return r;
  endfunction : prep_zero

  // ----------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------
  // The link clock is a plain divide-by-two of clk_i, so all link
  // logic here stays in one domain and needs no crossing. It runs
  // from reset onward so it is long stable before clock enable.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ~ck_q;
    end
  end

  assign link.ck = ck_q;

  // Pins change only as the link clock falls, giving the memory
  // half a link period of setup before its rising edge
  assign step = ck_q;
  assign done = (cnt == 16'h0000);

  // ----------------------------------------------------------------
  // Sequence selection
  // ----------------------------------------------------------------
  // Writes go out on entry to each mode slot, then a fixed gap
  assign mode_issue = ((state == ST_EXIT) && done)
                    || ((state == ST_MODE) && done && (idx != 2'h3));
  assign cal_issue  = (state == ST_MODE) && done && (idx == 2'h3);
  assign slot_sel   = MODE_ORDER[next_idx];

  // Word one always goes out with the loop enabled
  assign slot_word =
    (slot_sel == SEL_ZERO) ? prep_zero(mode_zero_i) :
    (slot_sel == SEL_ONE)  ? (mode_one_i
                              & ~(14'h0001 << LOOP_ENABLE_BIT)) :
    (slot_sel == SEL_TWO)  ? mode_two_i :
                             mode_three_i;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_idx   = idx;
    next_cnt   = done ? 16'h0000 : (cnt - 16'h0001);
    unique case (state)
      ST_HOLD: begin
        // Clock enable was low since reset, far beyond its setup
        if (done) begin
          next_state = ST_INIT;
          next_cnt   = 16'(INIT_WAIT_CK - 1);
        end
      end
      ST_INIT: begin
        if (done) begin
          next_state = ST_EXIT;
          next_cnt   = 16'(EXIT_WAIT_CK - 1);
        end
      end
      ST_EXIT: begin
        if (done) begin
          next_state = ST_MODE;
          next_idx   = 2'h0;
          next_cnt   = 16'(MODE_GAP_CK - 1);
        end
      end
      ST_MODE: begin
        if (done) begin
          if (idx == 2'h3) begin
            next_state = ST_CAL;
          end else begin
            next_idx = idx + 2'h1;
            next_cnt = 16'(MODE_GAP_CK - 1);
          end
        end
      end
      ST_CAL: begin
        next_state = ST_LOCK;
        next_cnt   = 16'(READY_WAIT_CK - 1);
      end
      ST_LOCK: begin
        if (done) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        next_cnt = 16'h0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= ST_HOLD;
      cnt   <= 16'(RESET_HOLD_CK - 1);
      idx   <= 2'h0;
    end else if (step) begin
      state <= next_state;
      cnt   <= next_cnt;
      idx   <= next_idx;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Reset, clock enable and ready follow the next state so
  // that they flip on the same falling edge as the state itself
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.reset_n             <= 1'b0;
      link.cke                 <= 1'b0;
      link.termination_control <= 1'b0;
      ready_o                  <= 1'b0;
    end else if (step) begin
      link.reset_n <= (next_state != ST_HOLD);
      // Once raised, enable stays high through lock and calibration
      link.cke     <= (next_state != ST_HOLD)
                   && (next_state != ST_INIT);
      // Held low so nominal termination may be enabled later
      link.termination_control <= 1'b0;
      ready_o      <= (next_state == ST_READY);
    end
  end

  // A NOP sits on the pins from reset, so it is registered well
  // before clock enable rises; only writes and calibration differ
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.cmd_n <= CMD_NOP;
      link.ba    <= 3'h0;
      link.addr  <= 14'h0000;
    end else if (step) begin
      if (mode_issue) begin
        link.cmd_n <= CMD_MODE;
        link.ba    <= {1'b0, slot_sel};
        link.addr  <= slot_word;
      end else if (cal_issue) begin
        link.cmd_n <= CMD_CAL;
        link.ba    <= 3'h0;
        link.addr  <= 14'h0001 << CAL_LONG_BIT;
      end else begin
        link.cmd_n <= CMD_NOP;
        link.ba    <= 3'h0;
        link.addr  <= 14'h0000;
      end
    end
  end

endmodule : dpi_mem_ctrl

//--- tb/dpi_link_props.sv
`timescale 1ns/10ps
module dpi_link_chk
  import dpi_pkg::*;
#(
  parameter int RESET_HOLD_CK = RESET_HOLD_CK_DEF,
  parameter int INIT_WAIT_CK  = INIT_WAIT_CK_DEF
) (
  input wire logic              clk_i,
  input wire logic              resetn_i,
  input wire logic              ck,
  input wire logic              reset_n,
  input wire logic              cke,
  input wire logic [3:0]        cmd_n,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              termination_control
);
  // ------------------------------------------------------------
  // Phase counters
  // ------------------------------------------------------------
  // Counted in system clocks; ck runs at half rate, so allow slack
  logic [15:0] low_cnt;
  logic [15:0] wait_cnt;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt  <= '0;
      wait_cnt <= '0;
    end else begin
      if (!reset_n) low_cnt <= low_cnt + 16'h0001;
      if (reset_n && !cke) wait_cnt <= wait_cnt + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_reset_hold_len: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(reset_n) |-> low_cnt >= 2 * RESET_HOLD_CK - 2)
    else $error("memory reset released too early");
  chk_cke_in_reset: assert property (
    @(posedge clk_i) disable iff (!resetn_i) !reset_n |-> !cke)
    else $error("clock enable high during memory reset");
  chk_init_wait_len: assert property (
    @(posedge clk_i) disable iff (!resetn_i)
    $rose(cke) |-> wait_cnt >= 2 * INIT_WAIT_CK - 2)
    else $error("clock enable raised before init wait");
  chk_nop_before_cke: assert property (
    @(posedge ck) disable iff (!reset_n)
    $rose(cke) |-> $past(cmd_n) == CMD_NOP)
    else $error("no idle command before clock enable");
  chk_cke_held_high: assert property (
    @(posedge ck) disable iff (!reset_n) $past(cke) |-> cke)
    else $error("clock enable dropped during init");
  chk_term_static: assert property (
    @(posedge ck) disable iff (!reset_n)
    cke && $past(cke) |-> $stable(termination_control)
    && !termination_control)
    else $error("termination control moved during init");
  chk_exit_wait: assert property (
    @(posedge ck) disable iff (!reset_n)
    cmd_n == CMD_MODE |-> $past(cke, 5))
    else $error("mode write too soon after clock enable");
  chk_mode_order: assert property (
    @(posedge ck) disable iff (!reset_n)
    (cmd_n == CMD_MODE && ba == 3'h2) |->
    ##4 (cmd_n == CMD_MODE && ba == 3'h3)
    ##4 (cmd_n == CMD_MODE && ba == 3'h1 && !addr[0])
    ##4 (cmd_n == CMD_MODE && ba == 3'h0 && addr[8]))
    else $error("mode writes out of order");
  chk_zero_reserved: assert property (
    @(posedge ck) disable iff (!reset_n)
    (cmd_n == CMD_MODE && ba == 3'h0) |-> !addr[13]
    && addr[11:9] != 3'h0 && addr[11:9] != 3'h7)
    else $error("bad reserved or recovery field in word zero");
  chk_cal_follows: assert property (
    @(posedge ck) disable iff (!reset_n)
    (cmd_n == CMD_MODE && ba == 3'h0) |->
    ##4 (cmd_n == CMD_CAL && addr[10]) ##1 cmd_n == CMD_NOP)
    else $error("long calibration missing after word zero");
endmodule : dpi_link_chk

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import dpi_pkg::*;
  // ------------------------------------------------------------
  // Stimulus tables and wiring
  // ------------------------------------------------------------
  // Short counts keep each power-up pass near 1100 clocks
  localparam int HOLD_CK = 8;
  localparam int WAIT_CK = 10;
  localparam logic [3:0] LAT_CODE [6] = '{4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'h2};
  localparam logic [3:0] LAT_EXP  [6] = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h0};
  localparam logic [2:0] REC_CODE [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
  localparam logic [3:0] REC_EXP  [6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC};
  logic              clk_i    = 1'b0;
  logic              resetn_i = 1'b0;
  logic [ADDR_W-1:0] mode_zero_i = 14'h0000;
  logic              ready_o;
  logic              term_o, order_o, test_o, pd_o, loop_o, cal_o, rsv_o;
  logic [1:0]        burst_o;
  logic [3:0]        lat_o, rec_o;
  int                errors    = 0;
  int                cmp_count = 0;
  int                n_loop    = 0;
  int                n_cal     = 0;

  always #20 clk_i = ~clk_i;

  dpi_link_if u_dpi_link_if ();
  dpi_mem_ctrl #(.RESET_HOLD_CK(HOLD_CK), .INIT_WAIT_CK(WAIT_CK))
    u_dpi_mem_ctrl (.clk_i(clk_i), .resetn_i(resetn_i),
    .mode_two_i(14'h0008), .mode_three_i(14'h0000), .mode_one_i(14'h0001),
    .mode_zero_i(mode_zero_i), .ready_o(ready_o), .link(u_dpi_link_if));
  dpi_mem_dev u_dpi_mem_dev (.link(u_dpi_link_if), .termination_on_o(term_o),
    .burst_size_o(burst_o), .burst_order_o(order_o),
    .read_latency_o(lat_o), .test_select_o(test_o), .recovery_o(rec_o),
    .powerdown_loop_o(pd_o), .loop_reset_o(loop_o), .cal_long_o(cal_o),
    .mode_reserved_o(rsv_o));
  dpi_link_chk #(.RESET_HOLD_CK(HOLD_CK), .INIT_WAIT_CK(WAIT_CK))
    u_dpi_link_chk (.clk_i(clk_i), .resetn_i(resetn_i),
    .ck(u_dpi_link_if.ck), .reset_n(u_dpi_link_if.reset_n),
    .cke(u_dpi_link_if.cke), .cmd_n(u_dpi_link_if.cmd_n),
    .ba(u_dpi_link_if.ba), .addr(u_dpi_link_if.addr),
    .termination_control(u_dpi_link_if.termination_control));

  // Sample pulses on the falling link clock, clear of their update edge;
  // counts restart with every reset so each pass sees only its own
  always @(negedge u_dpi_link_if.ck or negedge resetn_i) begin
    if (!resetn_i) begin
      n_loop = 0;
      n_cal  = 0;
    end else begin
      if (loop_o === 1'b1) n_loop++;
      if (cal_o === 1'b1) n_cal++;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic cmp_field(input logic [3:0] got, input logic [3:0] exp,
                           input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_field

  task automatic cmp_num(input int got, input int exp, input string what);
    cmp_count++;
    if (got != exp) begin
      errors++;
      $display("mismatch at %0t: %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : cmp_num

  // Reset the controller with a new word zero, then release it
  task automatic write_words(input logic [ADDR_W-1:0] w0);
    @(negedge clk_i);
    resetn_i = 1'b0;
    mode_zero_i = w0;
    repeat (20) @(negedge clk_i);
    resetn_i = 1'b1;
  endtask : write_words

  // Bounded wait for init to finish; too early is an error as well
  task automatic read_ready;
    int k;
    k = 0;
    while (ready_o !== 1'b1 && k < 3000) begin
      @(negedge clk_i);
      k++;
    end
    cmp_field({3'h0, ready_o}, 4'h1, "ready");
    cmp_num(int'(k >= 2 * (READY_WAIT_CK + 21)), 1, "early");
  endtask : read_ready

  task automatic complete_run;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    logic [ADDR_W-1:0] w;
    logic [1:0]        bs;
    logic              ts;
    logic              rs;
    for (int i = 0; i < 6; i++) begin
      bs = 2'(i % 4);
      ts = (i == 4);
      rs = (bs == 2'h3) || ts || (LAT_EXP[i] == 4'h0);
      w = {1'b0, i[1], REC_CODE[i], 1'b0, ts, LAT_CODE[i][3:1], i[0],
           LAT_CODE[i][0], bs};
      write_words(w);
      repeat (4) @(negedge clk_i);
      cmp_field({3'h0, term_o}, 4'h0, "termination early");
      read_ready;
      cmp_field({2'h0, burst_o}, {2'h0, bs}, "burst");
      cmp_field({3'h0, order_o}, {3'h0, i[0]}, "order");
      cmp_field(lat_o, LAT_EXP[i], "latency");
      cmp_field({3'h0, test_o}, {3'h0, ts}, "test");
      cmp_field(rec_o, REC_EXP[i], "recovery");
      cmp_field({3'h0, pd_o}, {3'h0, i[1]}, "pd loop");
      cmp_field({3'h0, rsv_o}, {3'h0, rs}, "reserved");
      cmp_field({3'h0, term_o}, 4'h0, "termination");
      cmp_field({3'h0, loop_o}, 4'h0, "loop reset left");
      cmp_num(n_loop, 1, "loop reset pulses");
      cmp_num(n_cal, 1, "calibration pulses");
    end
    complete_run;
  end

  // Six passes need about 7000 clocks
  initial begin
    repeat (12000) @(posedge clk_i);
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule : tb_top
